// ===== rtl/tmr_pair.sv
// Purpose: 8-bit timer channel pair with conflict arbitration
// Assumes: single clock, apb slave, one-wait-state three-cycle access
// Notes: channel 1 holds capture and compare c
//
// The implementer's own choices: register access over APB and the address map.
module tmr_pair (
  input wire logic core_clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic ext_clk, // external count clock
  input wire logic cap_in, // capture input
  output logic [tmr_pkg::NCH-1:0] tmo, // timer outputs
  output logic irq // level interrupt
);
  import tmr_pkg::*;

  logic [2:0] ext_s_q, ext_s_d, cap_s_q, cap_s_d;
  logic ext_f_q, ext_f_d, cap_f_q, cap_f_d;
  logic stop_q, stop_d, capen_q, capen_d;
  chan_cfg_t cfg_q [NCH];
  chan_cfg_t cfg_d [NCH];
  logic [7:0] cnt_q [NCH];
  logic [7:0] cnt_d [NCH];
  logic [7:0] cora_q [NCH];
  logic [7:0] cora_d [NCH];
  logic [7:0] corb_q [NCH];
  logic [7:0] corb_d [NCH];
  logic [7:0] corc_q, corc_d, capr_q, capr_d, capf_q, capf_d;
  logic [NSTS-1:0] sts_q, sts_d, ien_q, ien_d, sset;
  logic [NCH-1:0] eqa_q, eqa_d, eqb_q, eqb_d, lvl_q, lvl_d;
  logic eqc_q, eqc_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [NCH-1:0] tmo_q, tmo_d;
  logic irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  cap_st_t cap_q, cap_d;
  logic acc, hit, err, we;
  logic [31:0] rdat;
  logic [NCH-1:0] w_ctrl, w_cnt, w_cora, w_corb;
  logic w_stop, w_capen, w_corc, w_clr, w_ien;
  logic [NCH-1:0] ma, mb, clr, tick, fall;
  logic mc, cap_ev, run, casc16, cmcnt, halt, inc1;
  out_act_t act_a, act_b, act;

  function automatic logic [7:0] cha(input int i, input logic [7:0] off);
    cha = 8'(A_CH0 + 8'(i) * A_STRIDE) + off;
  endfunction

  // input synchronisers, level taken once stages two and three agree
  always_comb begin
    ext_s_d = {ext_s_q[1:0], ext_clk};
    cap_s_d = {cap_s_q[1:0], cap_in};
    ext_f_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_f_q;
    cap_f_d = (cap_s_q[1] == cap_s_q[2]) ? cap_s_q[2] : cap_f_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_s_q <= 3'h0;
      cap_s_q <= 3'h0;
      ext_f_q <= 1'b0;
      cap_f_q <= 1'b0;
    end else begin
      ext_s_q <= ext_s_d;
      cap_s_q <= cap_s_d;
      ext_f_q <= ext_f_d;
      cap_f_q <= cap_f_d;
    end
  end

  // apb decode and read mux
  always_comb begin
    acc = psel & penable & pready_q;
    rdat = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      A_STOP: rdat = 32'(stop_q);
      A_CAPEN: rdat = 32'(capen_q);
      A_CORC: rdat = 32'(corc_q);
      A_CAPR: rdat = 32'(capr_q);
      A_CAPF: rdat = 32'(capf_q);
      A_STS: rdat = 32'(sts_q);
      A_CLR: rdat = 32'h0000_0000;
      A_IEN: rdat = 32'(ien_q);
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (paddr == cha(i, O_CTRL)) begin
        hit = 1'b1;
        rdat = 32'(cfg_q[i]);
      end
      if (paddr == cha(i, O_CNT)) begin
        hit = 1'b1;
        rdat = 32'(cnt_q[i]);
      end
      if (paddr == cha(i, O_CORA)) begin
        hit = 1'b1;
        rdat = 32'(cora_q[i]);
      end
      if (paddr == cha(i, O_CORB)) begin
        hit = 1'b1;
        rdat = 32'(corb_q[i]);
      end
    end
    err = ~hit | (stop_q & (paddr != A_STOP));
    we = acc & pwrite & ~err;
    w_stop = we & (paddr == A_STOP);
    w_capen = we & (paddr == A_CAPEN);
    w_corc = we & (paddr == A_CORC);
    w_clr = we & (paddr == A_CLR);
    w_ien = we & (paddr == A_IEN);
    for (int i = 0; i < NCH; i++) begin
      w_ctrl[i] = we & (paddr == cha(i, O_CTRL));
      w_cnt[i] = we & (paddr == cha(i, O_CNT));
      w_cora[i] = we & (paddr == cha(i, O_CORA));
      w_corb[i] = we & (paddr == cha(i, O_CORB));
    end
    pready_d = psel & penable & ~pready_q;
    pslverr_d = pready_d & err;
    prdata_d = (pready_d & ~pwrite & ~err) ? rdat : prdata_q;
  end

  // selected clock levels, events and counter arbitration
  always_comb begin
    run = ~stop_q;
    pre_d = run ? pre_q + PRE_W'(1) : pre_q;
    casc16 = cfg_q[0].cks == CKS_CASC;
    cmcnt = cfg_q[1].cks == CKS_CASC;
    halt = casc16 & cmcnt;
    for (int i = 0; i < NCH; i++) begin
      case (cfg_q[i].cks)
        CKS_D2: lvl_d[i] = pre_q[PB_D2];
        CKS_D8: lvl_d[i] = pre_q[PB_D8];
        CKS_D32: lvl_d[i] = pre_q[PB_D32];
        CKS_EXTF: lvl_d[i] = ext_f_q;
        CKS_EXTR: lvl_d[i] = ~ext_f_q;
        default: lvl_d[i] = 1'b0;
      endcase
      // rewrite of select bits seen the same way as a clock edge
      fall[i] = run & lvl_q[i] & ~lvl_d[i];
      eqa_d[i] = cnt_q[i] == cora_q[i];
      eqb_d[i] = cnt_q[i] == corb_q[i];
      ma[i] = run & eqa_d[i] & ~eqa_q[i] & ~w_cora[i];
      mb[i] = run & eqb_d[i] & ~eqb_q[i] & ~w_corb[i];
      clr[i] = (cfg_q[i].cclr == CCLR_A & ma[i]) | (cfg_q[i].cclr == CCLR_B & mb[i]);
    end
    tick[1] = ~halt & (cmcnt ? ma[0] : fall[1]);
    inc1 = tick[1] & ~clr[1] & ~w_cnt[1];
    tick[0] = ~halt & (casc16 ? (inc1 & (cnt_q[1] == CNT_MAX)) : fall[0]);
    sset = '0;
    for (int i = 0; i < NCH; i++) begin
      cnt_d[i] = cnt_q[i];
      if (clr[i]) begin
        cnt_d[i] = CNT_ZERO;
      end else if (w_cnt[i]) begin
        cnt_d[i] = pwdata[7:0];
      end else if (tick[i]) begin
        cnt_d[i] = cnt_q[i] + 8'h01;
        sset[i * S_PER + S_OVF] = cnt_q[i] == CNT_MAX;
      end
      sset[i * S_PER + S_CMA] = ma[i];
      sset[i * S_PER + S_CMB] = mb[i];
      cfg_d[i] = w_ctrl[i] ? chan_cfg_t'(pwdata[CFG_W-1:0]) : cfg_q[i];
      cora_d[i] = w_cora[i] ? pwdata[7:0] : cora_q[i];
      corb_d[i] = w_corb[i] ? pwdata[7:0] : corb_q[i];
    end
  end

  // capture on falling edge after a rising edge
  always_comb begin
    cap_d = cap_q;
    cap_ev = 1'b0;
    case (cap_q)
      CAP_IDLE: begin
        if (run & capen_q & cap_f_d & ~cap_f_q) begin
          cap_d = CAP_ARMED;
        end
      end
      CAP_ARMED: begin
        if (~run | ~capen_q) begin
          cap_d = CAP_IDLE;
        end else if (~cap_f_d & cap_f_q) begin
          cap_ev = 1'b1;
          cap_d = CAP_IDLE;
        end
      end
      default: cap_d = CAP_IDLE;
    endcase
    capr_d = cap_ev ? cnt_q[CAPCH] : capr_q;
    capf_d = cap_ev ? cnt_q[CAPCH] : capf_q;
    eqc_d = cnt_q[CAPCH] == corc_q;
    mc = run & eqc_d & ~eqc_q & ~w_corc & ~cap_ev;
    corc_d = w_corc ? pwdata[7:0] : corc_q;
  end

  // outputs, status and control registers
  always_comb begin
    act_a = OUT_NONE;
    act_b = OUT_NONE;
    act = OUT_NONE;
    for (int i = 0; i < NCH; i++) begin
      act_a = ma[i] ? out_act_t'(cfg_q[i].os_a) : OUT_NONE;
      act_b = mb[i] ? out_act_t'(cfg_q[i].os_b) : OUT_NONE;
      // encoding order equals output priority
      act = (act_a > act_b) ? act_a : act_b;
      case (act)
        OUT_TOG: tmo_d[i] = ~tmo_q[i];
        OUT_HIGH: tmo_d[i] = 1'b1;
        OUT_LOW: tmo_d[i] = 1'b0;
        default: tmo_d[i] = tmo_q[i];
      endcase
    end
    // hardware set wins over software clear
    sts_d = (sts_q & ~(w_clr ? pwdata[NSTS-1:0] : '0)) | sset;
    sts_d[S_CAP] = sts_d[S_CAP] | cap_ev;
    sts_d[S_CMC] = sts_d[S_CMC] | mc;
    ien_d = w_ien ? pwdata[NSTS-1:0] : ien_q;
    irq_d = |(sts_d & ien_d);
    stop_d = w_stop ? pwdata[0] : stop_q;
    capen_d = w_capen ? pwdata[0] : capen_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stop_q <= 1'b1;
      capen_q <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        cfg_q[i] <= '0;
        cnt_q[i] <= CNT_ZERO;
        cora_q[i] <= CNT_MAX;
        corb_q[i] <= CNT_MAX;
      end
      corc_q <= CNT_MAX;
      capr_q <= CNT_ZERO;
      capf_q <= CNT_ZERO;
      sts_q <= '0;
      ien_q <= '0;
      eqa_q <= '0;
      eqb_q <= '0;
      eqc_q <= 1'b0;
      lvl_q <= '0;
      pre_q <= '0;
      tmo_q <= '0;
      irq_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      cap_q <= CAP_IDLE;
    end else begin
      stop_q <= stop_d;
      capen_q <= capen_d;
      cfg_q <= cfg_d;
      cnt_q <= cnt_d;
      cora_q <= cora_d;
      corb_q <= corb_d;
      corc_q <= corc_d;
      capr_q <= capr_d;
      capf_q <= capf_d;
      sts_q <= sts_d;
      ien_q <= ien_d;
      eqa_q <= eqa_d;
      eqb_q <= eqb_d;
      eqc_q <= eqc_d;
      lvl_q <= lvl_d;
      pre_q <= pre_d;
      tmo_q <= tmo_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      cap_q <= cap_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tmo = tmo_q;
  assign irq = irq_q;
endmodule

// ===== rtl/tmr_pkg.sv
// Purpose: constants and types for the cascaded 8-bit timer pair
// Assumes: apb slave, 8-bit byte address, 32-bit data
// Notes: channel 1 is the capture-capable channel
// Behaviour
// - clear request during a counter write clears it; written value dropped
// - count-up during a counter write: value loaded, increment dropped
// - compare write in the same cycle as its match suppresses the match
// - capture coinciding with compare-c match wins; match suppressed
// - simultaneous a/b matches: toggle, then high, then low, then none
// - internal clock source counts on each falling edge of selected clock
// - clock-select rewrite turning level high to low counts once
// - internal/external source change counts once by same edge detect
// - both cascade modes together: neither counter of the pair counts
// - module starts stopped after reset; clearing stop bit enables operation
// - timer registers accessible only while stop is released
// - select code 100 cascades: 16-bit count or count of ch0 match a
// - overflow flag set when counter wraps from ff to 00
// - capture falling edge after rising edge copies count to both captures
package tmr_pkg;
  localparam int NCH = 2;
  localparam int CAPCH = 1;
  localparam int NSTS = 8;
  localparam logic [7:0] A_STOP = 8'h00;
  localparam logic [7:0] A_CAPEN = 8'h04;
  localparam logic [7:0] A_CH0 = 8'h10;
  localparam logic [7:0] A_STRIDE = 8'h10;
  localparam logic [7:0] O_CTRL = 8'h00;
  localparam logic [7:0] O_CNT = 8'h04;
  localparam logic [7:0] O_CORA = 8'h08;
  localparam logic [7:0] O_CORB = 8'h0C;
  localparam logic [7:0] A_CORC = 8'h30;
  localparam logic [7:0] A_CAPR = 8'h34;
  localparam logic [7:0] A_CAPF = 8'h38;
  localparam logic [7:0] A_STS = 8'h40;
  localparam logic [7:0] A_CLR = 8'h44;
  localparam logic [7:0] A_IEN = 8'h48;
  localparam logic [2:0] CKS_OFF = 3'h0;
  localparam logic [2:0] CKS_D2 = 3'h1;
  localparam logic [2:0] CKS_D8 = 3'h2;
  localparam logic [2:0] CKS_D32 = 3'h3;
  localparam logic [2:0] CKS_CASC = 3'h4;
  localparam logic [2:0] CKS_EXTF = 3'h5;
  localparam logic [2:0] CKS_EXTR = 3'h6;
  localparam int PB_D2 = 0;
  localparam int PB_D8 = 2;
  localparam int PB_D32 = 4;
  localparam int PRE_W = 5;
  localparam logic [1:0] CCLR_NONE = 2'h0;
  localparam logic [1:0] CCLR_A = 2'h1;
  localparam logic [1:0] CCLR_B = 2'h2;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam int S_CMA = 0;
  localparam int S_CMB = 1;
  localparam int S_OVF = 2;
  localparam int S_PER = 3;
  localparam int S_CAP = 6;
  localparam int S_CMC = 7;
  typedef enum logic [1:0] {
    OUT_NONE = 2'h0,
    OUT_LOW = 2'h1,
    OUT_HIGH = 2'h2,
    OUT_TOG = 2'h3
  } out_act_t;
  typedef struct packed {
    logic [1:0] os_b;
    logic [1:0] os_a;
    logic [1:0] cclr;
    logic [2:0] cks;
  } chan_cfg_t;
  localparam int CFG_W = 9;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'h0,
    CAP_ARMED = 2'h1
  } cap_st_t;
endpackage

// ===== sim/tmr_pair_assertions.sv
// Purpose: port checks for tmr_pair
// Assumes: stop bit tracked from completed apb writes
// Notes: bound to every tmr_pair
module tmr_pair_assertions (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [tmr_pkg::NCH-1:0] tmo, // outputs
  input wire logic irq // interrupt
);
  import tmr_pkg::*;
  logic stop_q;
  logic stop_d;
  logic done;
  assign done = psel && penable && pready;
  always_comb begin
    stop_d = stop_q;
    if (done && pwrite && !pslverr && paddr == A_STOP) begin
      stop_d = pwdata[0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stop_q <= 1'b1;
    end else begin
      stop_q <= stop_d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_ready_late: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_stop_refuse: assert property (done && stop_q && paddr != A_STOP |-> pslverr)
    else $error("access while stopped not refused");
  chk_unmapped_err: assert property (done && (paddr == 8'h08 || paddr > A_IEN) |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_read_hold: assert property (!(psel && penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved without a read");
  chk_stop_tmo: assert property (stop_q && $past(stop_q) |-> $stable(tmo))
    else $error("tmo moved while stopped");
  chk_stop_irq: assert property (stop_q && $past(stop_q) |-> $stable(irq))
    else $error("irq moved while stopped");
endmodule
bind tmr_pair tmr_pair_assertions u_chk (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .tmo, .irq);

// ===== sim/tmr_pair_tb.sv
// Purpose: directed test of tmr_pair conflicts and counting
// Assumes: ext_clk held still between pulses, so counts are exact
// Notes: channel 0 counts ext_clk falling edges
module tmr_pair_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmr_pkg::*;
  localparam logic [7:0] C0 = A_CH0;
  localparam logic [7:0] C1 = A_CH0 + A_STRIDE;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_clk = 1'b0;
  logic cap_in = 1'b0;
  logic [NCH-1:0] tmo;
  logic irq;
  logic [31:0] rdata;
  logic rerr;
  logic e;
  int p;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  tmr_pair u_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_clk, .cap_in, .tmo, .irq);
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // look mid-cycle so the edge that raises pready is not raced
    do @(negedge core_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      ext_clk <= 1'b1;
      wt(6);
      ext_clk <= 1'b0;
      wt(6);
    end
    wt(4);
  endtask
  function automatic logic [31:0] cf(input logic [1:0] ob, input logic [1:0] oa,
    input logic [2:0] ck);
    chan_cfg_t c;
    c = '{os_b: ob, os_a: oa, cclr: CCLR_NONE, cks: ck};
    return {23'h0, c};
  endfunction
  initial begin
    wt(2);
    rst <= 1'b0;
    rd(A_STOP, 32'h1);
    apb(1'b0, C0 + O_CNT, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, A_STOP, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, C0 + O_CORA, 32'h2);
    apb(1'b1, C0 + O_CORB, 32'h2);
    e = 1'b0;
    for (int a = 0; a < 4; a++) begin
      for (int b = 0; b < 4; b++) begin
        apb(1'b1, C0 + O_CTRL, cf(b[1:0], a[1:0], CKS_EXTF));
        apb(1'b1, C0 + O_CNT, 32'h1);
        pulse(1);
        p = (a > b) ? a : b;
        if (p == 3) e = ~e;
        else if (p != 0) e = (p == 2);
        chk({31'h0, tmo[0]}, {31'h0, e});
      end
    end
    apb(1'b1, A_CLR, 32'hFF);
    apb(1'b1, A_IEN, 32'h4);
    apb(1'b1, C0 + O_CNT, 32'hFE);
    pulse(2);
    rd(C0 + O_CNT, 32'h0);
    rd(A_STS, 32'h4);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_IEN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, A_CLR, 32'h4);
    rd(A_STS, 32'h0);
    apb(1'b1, C1 + O_CTRL, cf(2'h0, 2'h0, CKS_CASC));
    apb(1'b1, C1 + O_CNT, 32'h22);
    apb(1'b1, C0 + O_CNT, 32'h1);
    pulse(1);
    rd(C1 + O_CNT, 32'h23);
    apb(1'b1, C0 + O_CTRL, cf(2'h0, 2'h0, CKS_CASC));
    apb(1'b1, C0 + O_CNT, 32'h1);
    apb(1'b1, C1 + O_CNT, 32'hFF);
    // fresh match a on ch0 would count ch1 if the pair were not halted
    apb(1'b1, C0 + O_CNT, 32'h2);
    pulse(2);
    rd(C0 + O_CNT, 32'h2);
    rd(C1 + O_CNT, 32'hFF);
    apb(1'b1, C1 + O_CTRL, 32'h0);
    apb(1'b1, C1 + O_CNT, 32'h3C);
    apb(1'b1, A_CAPEN, 32'h1);
    apb(1'b1, A_CLR, 32'hFF);
    apb(1'b1, A_IEN, 32'h40);
    cap_in <= 1'b1;
    wt(8);
    cap_in <= 1'b0;
    wt(8);
    chk({31'h0, irq}, 32'h1);
    rd(A_CAPR, 32'h3C);
    rd(A_CAPF, 32'h3C);
    apb(1'b1, A_STOP, 32'h1);
    apb(1'b0, A_CAPR, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    end_sim();
  end
endmodule
